// >>> rtl/eir_top.v
// Event and interrupt routing: transfer channel events and CPU interrupt selector
// Assumes Avalon-MM master on the core clock; ext_int_pin is asynchronous
//
// Notes on behaviour
// - Channels 0-3: host, timers 0/1, wide refresh
// - Channels 4-11, 48-55 take gpio events
// - Channels 12-15, 17-18 take serial events
// - Channel 19 timer 2, 20 narrow refresh
// - Channels 28-31 take decoder rx/tx events
// - Channel 32 cell rx, 40 cell tx
// - Reserved and unattached channels trigger only on completion events
// - Absent peripherals' channel events masked; completion events still assert those channels
// - Completion events also synchronize every channel
// - Sixteen prioritized interrupts, zero is reset
// - Interrupts 0-3 fixed, not selectable
// - Interrupts 4-15 default to documented sources
// - Selector registers at 0x019c0000 and 0x019c0004
// - Events captured even while channel disabled
// - Six 5-bit fields per selector register
// - Selector code table for source lines
//
// Design decision made here: the Avalon-MM register port.
`default_nettype none
module eir_top #(
  parameter HAS_PCI = 1,
  parameter HAS_CELL = 1,
  parameter HAS_DECODERS = 1
) (
  input wire clock,
  input wire rst,
  input wire [31:0] address,
  input wire read,
  input wire write,
  input wire [3:0] byteenable,
  input wire [31:0] writedata,
  output wire [31:0] readdata,
  output wire waitrequest,
  input wire reset_event,
  input wire nmi_event,
  input wire host_event,
  input wire timer0_event,
  input wire timer1_event,
  input wire timer2_event,
  input wire wide_mem_refresh_event,
  input wire narrow_mem_refresh_event,
  input wire [15:0] gpio_event,
  input wire [3:0] ext_int_pin,
  input wire serial0_tx_event,
  input wire serial0_rx_event,
  input wire serial1_tx_event,
  input wire serial1_rx_event,
  input wire serial2_tx_event,
  input wire serial2_rx_event,
  input wire conv_decoder_rx_event,
  input wire conv_decoder_tx_event,
  input wire turbo_decoder_rx_event,
  input wire turbo_decoder_tx_event,
  input wire cell_rx_event,
  input wire cell_tx_event,
  input wire xfer_done_irq,
  input wire emu_dtdma_event,
  input wire emu_rx_event,
  input wire emu_tx_event,
  input wire cell_irq,
  input wire conv_decoder_irq,
  input wire turbo_decoder_irq,
  input wire [63:0] xfer_done_event,
  input wire [63:0] alt_xfer_done_event,
  output wire [63:0] chan_sync,
  output wire [63:0] chan_request,
  output wire [15:0] cpu_irq,
  output wire irq
);
`include "eir_map.vh"
  ////////////////////////////////////////////////////////////////////////
  // Declarations
  reg [31:0] sel_high_ff;
  reg [31:0] nxt_sel_high;
  reg [31:0] sel_low_ff;
  reg [31:0] nxt_sel_low;
  reg [1:0] status_ff;
  reg [1:0] nxt_status;
  reg [1:0] mask_ff;
  reg [1:0] nxt_mask;
  reg [63:0] capt_ff;
  reg [63:0] nxt_capt;
  reg [63:0] ena_ff;
  reg [63:0] nxt_ena;
  reg [63:0] chan_sync_ff;
  reg [63:0] chan_req_ff;
  reg [15:0] cpu_irq_ff;
  reg [15:0] nxt_cpu_irq;
  reg [31:0] readdata_ff;
  reg [31:0] nxt_readdata;
  reg ack_ff;
  reg irq_ff;
  reg [3:0] pin_meta_ff;
  reg [3:0] pin_sync_ff;
  reg [3:0] pin_prev_ff;
  reg [31:0] src_line_ff;
  reg [31:0] nxt_src_line;
  wire [31:0] bmask;
  wire [31:0] wr_val;
  wire req;
  wire wr_fire;
  wire rd_fire;
  wire [3:0] pin_edge;
  wire [15:0] gpio_all;
  wire [63:0] periph_evt;
  wire [63:0] comb_evt;
  wire [63:0] clr_capt;
  wire [11:0] mux_out;
  wire [63:0] new_hit;
  wire [63:0] miss_hit;
  wire [1:0] stat_set;
  wire [1:0] stat_clr;
  ////////////////////////////////////////////////////////////////////////
  // Avalon slave handshake
  assign req = read | write;
  assign waitrequest = req & ~ack_ff;
  assign wr_fire = write & ack_ff;
  assign rd_fire = read & ~ack_ff;
  assign bmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                  {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign wr_val = writedata & bmask;
  assign readdata = readdata_ff;
  always @(posedge clock) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // External pin synchronizer and edge detect
  always @(posedge clock) begin
    if (rst) begin
      pin_meta_ff <= 4'h0;
      pin_sync_ff <= 4'h0;
      pin_prev_ff <= 4'h0;
    end else begin
      pin_meta_ff <= ext_int_pin;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end
  assign pin_edge = pin_sync_ff & ~pin_prev_ff;
  assign gpio_all = {gpio_event[15:8], gpio_event[7:4] | pin_edge,
                     gpio_event[3:0]};
  ////////////////////////////////////////////////////////////////////////
  // Fixed channel event map
  eir_chan_map #(
    .HAS_PCI(HAS_PCI),
    .HAS_CELL(HAS_CELL),
    .HAS_DECODERS(HAS_DECODERS)
  ) u_map (
    .host_event(host_event),
    .timer0_event(timer0_event),
    .timer1_event(timer1_event),
    .timer2_event(timer2_event),
    .wide_mem_refresh_event(wide_mem_refresh_event),
    .narrow_mem_refresh_event(narrow_mem_refresh_event),
    .gpio_event(gpio_all),
    .serial0_tx_event(serial0_tx_event),
    .serial0_rx_event(serial0_rx_event),
    .serial1_tx_event(serial1_tx_event),
    .serial1_rx_event(serial1_rx_event),
    .serial2_tx_event(serial2_tx_event),
    .serial2_rx_event(serial2_rx_event),
    .conv_decoder_rx_event(conv_decoder_rx_event),
    .conv_decoder_tx_event(conv_decoder_tx_event),
    .turbo_decoder_rx_event(turbo_decoder_rx_event),
    .turbo_decoder_tx_event(turbo_decoder_tx_event),
    .cell_rx_event(cell_rx_event),
    .cell_tx_event(cell_tx_event),
    .periph_evt(periph_evt)
  );
  assign comb_evt = periph_evt | xfer_done_event | alt_xfer_done_event;
  ////////////////////////////////////////////////////////////////////////
  // Event capture, enables and channel requests
  assign clr_capt = (wr_fire && address == `EIR_ADDR_CAPT_LOW) ?
                    {32'h00000000, wr_val} :
                    (wr_fire && address == `EIR_ADDR_CAPT_HIGH) ?
                    {wr_val, 32'h00000000} : 64'h0;
  assign new_hit = chan_sync_ff & ~capt_ff & ena_ff;
  assign miss_hit = chan_sync_ff & capt_ff;
  always @* begin
    nxt_capt = (capt_ff & ~clr_capt) | chan_sync_ff;
    nxt_ena = ena_ff;
    if (wr_fire && address == `EIR_ADDR_ENA_LOW) begin
      nxt_ena[31:0] = (ena_ff[31:0] & ~bmask) | wr_val;
    end else if (wr_fire && address == `EIR_ADDR_ENA_HIGH) begin
      nxt_ena[63:32] = (ena_ff[63:32] & ~bmask) | wr_val;
    end
  end
  always @(posedge clock) begin
    if (rst) begin
      chan_sync_ff <= 64'h0;
      capt_ff <= 64'h0;
      ena_ff <= 64'h0;
      chan_req_ff <= 64'h0;
    end else begin
      chan_sync_ff <= comb_evt;
      capt_ff <= nxt_capt;
      ena_ff <= nxt_ena;
      chan_req_ff <= nxt_capt & nxt_ena;
    end
  end
  assign chan_sync = chan_sync_ff;
  assign chan_request = chan_req_ff;
  ////////////////////////////////////////////////////////////////////////
  // Selector registers
  always @* begin
    nxt_sel_high = sel_high_ff;
    nxt_sel_low = sel_low_ff;
    if (wr_fire && address == `EIR_ADDR_SEL_HIGH) begin
      nxt_sel_high = ((sel_high_ff & ~bmask) | wr_val) & `EIR_SEL_WMASK;
    end else if (wr_fire && address == `EIR_ADDR_SEL_LOW) begin
      nxt_sel_low = ((sel_low_ff & ~bmask) | wr_val) & `EIR_SEL_WMASK;
    end
  end
  always @(posedge clock) begin
    if (rst) begin
      sel_high_ff <= `EIR_SEL_HIGH_RST;
      sel_low_ff <= `EIR_SEL_LOW_RST;
    end else begin
      sel_high_ff <= nxt_sel_high;
      sel_low_ff <= nxt_sel_low;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Interrupt source lines
  always @* begin
    nxt_src_line = 32'h00000000;
    nxt_src_line[0] = host_event & (HAS_PCI != 0);
    nxt_src_line[1] = timer0_event;
    nxt_src_line[2] = timer1_event;
    nxt_src_line[3] = wide_mem_refresh_event;
    nxt_src_line[7:4] = gpio_all[7:4];
    nxt_src_line[8] = xfer_done_irq;
    nxt_src_line[9] = emu_dtdma_event;
    nxt_src_line[10] = emu_rx_event;
    nxt_src_line[11] = emu_tx_event;
    nxt_src_line[12] = serial0_tx_event;
    nxt_src_line[13] = serial0_rx_event;
    nxt_src_line[14] = serial1_tx_event;
    nxt_src_line[15] = serial1_rx_event;
    nxt_src_line[16] = gpio_all[0];
    nxt_src_line[17] = serial2_tx_event;
    nxt_src_line[18] = serial2_rx_event;
    nxt_src_line[19] = timer2_event;
    nxt_src_line[20] = narrow_mem_refresh_event;
    nxt_src_line[`EIR_CODE_CELL] = cell_irq & (HAS_CELL != 0);
    nxt_src_line[`EIR_CODE_CONV] = conv_decoder_irq & (HAS_DECODERS != 0);
    nxt_src_line[`EIR_CODE_TURBO] = turbo_decoder_irq & (HAS_DECODERS != 0);
  end
  always @(posedge clock) begin
    if (rst) begin
      src_line_ff <= 32'h00000000;
    end else begin
      src_line_ff <= nxt_src_line;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Maskable interrupt selectors
  genvar gi;
  generate
    for (gi = 0; gi < `EIR_NUM_MASKABLE; gi = gi + 1) begin : g_sel
      localparam integer FJ = gi % `EIR_FIELDS_PER_REG;
      localparam integer LSB = (FJ < 3) ? FJ * 5 : FJ * 5 + 1;
      wire [4:0] fsel;
      if (gi < `EIR_FIELDS_PER_REG) begin : g_low
        assign fsel = sel_low_ff[LSB +: `EIR_SEL_W];
      end else begin : g_high
        assign fsel = sel_high_ff[LSB +: `EIR_SEL_W];
      end
      eir_sel_mux u_mux (
        .sel(fsel),
        .lines(src_line_ff),
        .chosen(mux_out[gi])
      );
    end
  endgenerate
  always @* begin
    // bit 0 reset, bit 15 lowest
    // fixed sources for 0 to 3
    nxt_cpu_irq = {mux_out, 2'b00, nmi_event, reset_event};
  end
  always @(posedge clock) begin
    if (rst) begin
      cpu_irq_ff <= 16'h0000;
    end else begin
      cpu_irq_ff <= nxt_cpu_irq;
    end
  end
  assign cpu_irq = cpu_irq_ff;
  ////////////////////////////////////////////////////////////////////////
  // Block interrupt status and mask
  assign stat_set[`EIR_STAT_NEW] = |new_hit;
  assign stat_set[`EIR_STAT_MISS] = |miss_hit;
  assign stat_clr = (wr_fire && address == `EIR_ADDR_STATUS) ?
                    wr_val[1:0] : 2'b00;
  always @* begin
    nxt_status = (status_ff & ~stat_clr) | stat_set;
    nxt_mask = mask_ff;
    if (wr_fire && address == `EIR_ADDR_MASK) begin
      nxt_mask = (mask_ff & ~bmask[1:0]) | wr_val[1:0];
    end
  end
  always @(posedge clock) begin
    if (rst) begin
      status_ff <= 2'b00;
      mask_ff <= 2'b00;
      irq_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      irq_ff <= |(nxt_status & nxt_mask);
    end
  end
  assign irq = irq_ff;
  ////////////////////////////////////////////////////////////////////////
  // Read data
  always @* begin
    nxt_readdata = readdata_ff;
    if (rd_fire) begin
      if (address == `EIR_ADDR_SEL_HIGH) begin
        nxt_readdata = sel_high_ff;
      end else if (address == `EIR_ADDR_SEL_LOW) begin
        nxt_readdata = sel_low_ff;
      end else if (address == `EIR_ADDR_STATUS) begin
        nxt_readdata = {30'h00000000, status_ff};
      end else if (address == `EIR_ADDR_MASK) begin
        nxt_readdata = {30'h00000000, mask_ff};
      end else if (address == `EIR_ADDR_CAPT_LOW) begin
        nxt_readdata = capt_ff[31:0];
      end else if (address == `EIR_ADDR_CAPT_HIGH) begin
        nxt_readdata = capt_ff[63:32];
      end else if (address == `EIR_ADDR_ENA_LOW) begin
        nxt_readdata = ena_ff[31:0];
      end else if (address == `EIR_ADDR_ENA_HIGH) begin
        nxt_readdata = ena_ff[63:32];
      end else if (address == `EIR_ADDR_IRQ_STATE) begin
        nxt_readdata = {16'h0000, cpu_irq_ff};
      end else begin
        nxt_readdata = 32'h00000000;
      end
    end
  end
  always @(posedge clock) begin
    if (rst) begin
      readdata_ff <= 32'h00000000;
    end else begin
      readdata_ff <= nxt_readdata;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/eir_map.vh
// Register map, field layout, reset values and selector codes
// Assumes a 32-bit byte address on the register bus
`ifndef EIR_MAP_VH
`define EIR_MAP_VH
`define EIR_ADDR_SEL_HIGH 32'h019c0000
`define EIR_ADDR_SEL_LOW 32'h019c0004
`define EIR_ADDR_STATUS 32'h019c0008
`define EIR_ADDR_MASK 32'h019c000c
`define EIR_ADDR_CAPT_LOW 32'h019c0010
`define EIR_ADDR_CAPT_HIGH 32'h019c0014
`define EIR_ADDR_ENA_LOW 32'h019c0018
`define EIR_ADDR_ENA_HIGH 32'h019c001c
`define EIR_ADDR_IRQ_STATE 32'h019c0020
`define EIR_SEL_HIGH_RST 32'h08202d43
`define EIR_SEL_LOW_RST 32'h250718a4
`define EIR_SEL_WMASK 32'h7fff7fff
`define EIR_SEL_W 5
`define EIR_FIELD0 0
`define EIR_FIELD3 16
`define EIR_FIELDS_PER_REG 6
`define EIR_NUM_MASKABLE 12
`define EIR_STAT_W 2
`define EIR_STAT_NEW 0
`define EIR_STAT_MISS 1
`define EIR_CODE_HOST 5'h00
`define EIR_CODE_CELL 5'h17
`define EIR_CODE_CONV 5'h1e
`define EIR_CODE_TURBO 5'h1f
`define EIR_RSV_LO 5'h18
`define EIR_RSV_HI 5'h1d
`endif

// >>> rtl/eir_sel_mux.v
// One 32-way interrupt source selector
// Assumes event lines are already registered in the core clock domain
`default_nettype none
module eir_sel_mux (
  input wire [4:0] sel,
  input wire [31:0] lines,
  output wire chosen
);
`include "eir_map.vh"
  wire rsv;
  assign rsv = (sel >= `EIR_RSV_LO) && (sel <= `EIR_RSV_HI);
  assign chosen = rsv ? 1'b0 : lines[sel];
endmodule
`default_nettype wire

// >>> rtl/eir_chan_map.v
// Fixed peripheral event to transfer channel association
// Assumes all event inputs are single-clock pulses in the core domain
`default_nettype none
module eir_chan_map #(
  parameter HAS_PCI = 1,
  parameter HAS_CELL = 1,
  parameter HAS_DECODERS = 1
) (
  input wire host_event,
  input wire timer0_event,
  input wire timer1_event,
  input wire timer2_event,
  input wire wide_mem_refresh_event,
  input wire narrow_mem_refresh_event,
  input wire [15:0] gpio_event,
  input wire serial0_tx_event,
  input wire serial0_rx_event,
  input wire serial1_tx_event,
  input wire serial1_rx_event,
  input wire serial2_tx_event,
  input wire serial2_rx_event,
  input wire conv_decoder_rx_event,
  input wire conv_decoder_tx_event,
  input wire turbo_decoder_rx_event,
  input wire turbo_decoder_tx_event,
  input wire cell_rx_event,
  input wire cell_tx_event,
  output wire [63:0] periph_evt
);
  wire pci_ok = (HAS_PCI != 0);
  wire cell_ok = (HAS_CELL != 0);
  wire dec_ok = (HAS_DECODERS != 0);
  assign periph_evt[0] = host_event & pci_ok;
  assign periph_evt[1] = timer0_event;
  assign periph_evt[2] = timer1_event;
  assign periph_evt[3] = wide_mem_refresh_event;
  assign periph_evt[7:4] = gpio_event[7:4];
  assign periph_evt[11:8] = gpio_event[3:0];
  assign periph_evt[55:48] = gpio_event[15:8];
  assign periph_evt[12] = serial0_tx_event;
  assign periph_evt[13] = serial0_rx_event;
  assign periph_evt[14] = serial1_tx_event;
  assign periph_evt[15] = serial1_rx_event;
  assign periph_evt[17] = serial2_tx_event;
  assign periph_evt[18] = serial2_rx_event;
  assign periph_evt[19] = timer2_event;
  assign periph_evt[20] = narrow_mem_refresh_event;
  assign periph_evt[28] = conv_decoder_rx_event & dec_ok;
  assign periph_evt[29] = conv_decoder_tx_event & dec_ok;
  assign periph_evt[30] = turbo_decoder_rx_event & dec_ok;
  assign periph_evt[31] = turbo_decoder_tx_event & dec_ok;
  assign periph_evt[32] = cell_rx_event & cell_ok;
  assign periph_evt[40] = cell_tx_event & cell_ok;
  assign periph_evt[16] = 1'b0;
  assign periph_evt[27:21] = 7'h00;
  assign periph_evt[39:33] = 7'h00;
  assign periph_evt[47:41] = 7'h00;
  assign periph_evt[63:56] = 8'h00;
endmodule
`default_nettype wire

// >>> sim/eir_chk.sv
// Checker: channel sync map, fixed interrupts, bus wait state
// Assumes bind onto the top module; external pins low during reset
`default_nettype none
module eir_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic reset_event,
  input wire logic host_event,
  input wire logic timer0_event,
  input wire logic timer1_event,
  input wire logic wide_mem_refresh_event,
  input wire logic [15:0] gpio_event,
  input wire logic [3:0] ext_int_pin,
  input wire logic [63:0] xfer_done_event,
  input wire logic [63:0] alt_xfer_done_event,
  input wire logic [63:0] chan_sync,
  input wire logic [15:0] cpu_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] d;
  assign d = xfer_done_event | alt_xfer_done_event;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_chan_fixed:
  assert property (!$past(rst) |-> chan_sync[3:0] ==
    $past(d[3:0] | {wide_mem_refresh_event, timer1_event, timer0_event, host_event}))
    else $error("chan 0-3 mismatch");
  a_chan_gpio:
  assert property (!$past(rst) |-> {chan_sync[55:48], chan_sync[11:4]} ==
    ($past({d[55:48], d[11:4]} | {gpio_event[15:8], gpio_event[3:0], gpio_event[7:4]}) |
    {12'h000, $past(ext_int_pin, 3) & ~$past(ext_int_pin, 4)}))
    else $error("gpio channel mismatch");
  a_chan_top:
  assert property (!$past(rst) |-> chan_sync[63:56] == $past(d[63:56]))
    else $error("chan 56-63 mismatch");
  a_chan_spare:
  assert property (!$past(rst) |-> chan_sync[27:21] == $past(d[27:21]))
    else $error("chan 21-27 mismatch");
  a_chan_gap:
  assert property (!$past(rst) |-> {chan_sync[47:41], chan_sync[39:33], chan_sync[16]} ==
    $past({d[47:41], d[39:33], d[16]}))
    else $error("empty channel fired");
  a_irq_fixed:
  assert property (cpu_irq[3:2] == 2'h0)
    else $error("cpu irq 2-3 active");
  a_irq_reset:
  assert property ($rose(reset_event) |-> ##[1:2] cpu_irq[0])
    else $error("reset interrupt missing");
  a_bus_wait:
  assert property ($rose(read | write) |-> waitrequest ##1 (!waitrequest && (read | write)))
    else $error("bus wait state wrong");
  c_sync: cover property (chan_sync[1]);
  c_irq: cover property (cpu_irq[4]);
  c_read: cover property (read && !waitrequest);
endmodule
bind eir_top eir_chk u_chk (.*);
`default_nettype wire

// >>> sim/eir_far.sv
// Far-side model: transfer controller and CPU interrupt inputs
// Assumes one clock; completion commands come from the bench
`default_nettype none
module eir_far (
  input wire logic clock,
  input wire logic rst,
  input wire logic clr,
  input wire logic [63:0] done_cmd,
  input wire logic [63:0] alt_cmd,
  input wire logic [63:0] chan_sync,
  input wire logic [15:0] cpu_irq,
  output logic [63:0] xfer_done_event,
  output logic [63:0] alt_xfer_done_event,
  output logic [63:0] seen_sync,
  output logic [15:0] seen_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clock) begin
    xfer_done_event <= rst ? 64'h0 : done_cmd;
    alt_xfer_done_event <= rst ? 64'h0 : alt_cmd;
    seen_sync <= (rst | clr) ? 64'h0 : seen_sync | chan_sync;
    seen_irq <= (rst | clr) ? 16'h0 : seen_irq | cpu_irq;
  end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Testbench: routing map, selector, capture, interrupt and bus checks
// Assumes the far-side model and the checker are compiled first
`default_nettype none
`include "eir_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic clr = 1'b0;
  logic waitrequest, irq;
  logic [26:0] ev = 27'h0;
  logic [15:0] gpio = 16'h0;
  logic [3:0] be = 4'hf;
  logic [3:0] pin = 4'h0;
  logic [15:0] cpu_irq, seen_irq;
  logic [31:0] address = 32'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd;
  logic [63:0] done_cmd = 64'h0;
  logic [63:0] alt_cmd = 64'h0;
  logic [63:0] xd, xa, chan_sync, chan_request, seen_sync;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #5 clock = ~clock;
  eir_top u_dut (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(be), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .reset_event(ev[25]), .nmi_event(ev[26]),
    .host_event(ev[0]), .timer0_event(ev[1]), .timer1_event(ev[2]), .timer2_event(ev[3]),
    .wide_mem_refresh_event(ev[4]), .narrow_mem_refresh_event(ev[5]),
    .gpio_event(gpio), .ext_int_pin(pin),
    .serial0_tx_event(ev[6]), .serial0_rx_event(ev[7]), .serial1_tx_event(ev[8]),
    .serial1_rx_event(ev[9]), .serial2_tx_event(ev[10]), .serial2_rx_event(ev[11]),
    .conv_decoder_rx_event(ev[12]), .conv_decoder_tx_event(ev[13]),
    .turbo_decoder_rx_event(ev[14]), .turbo_decoder_tx_event(ev[15]),
    .cell_rx_event(ev[16]), .cell_tx_event(ev[17]), .xfer_done_irq(ev[18]),
    .emu_dtdma_event(ev[19]), .emu_rx_event(ev[20]), .emu_tx_event(ev[21]),
    .cell_irq(ev[22]), .conv_decoder_irq(ev[23]), .turbo_decoder_irq(ev[24]),
    .xfer_done_event(xd), .alt_xfer_done_event(xa), .chan_sync(chan_sync),
    .chan_request(chan_request), .cpu_irq(cpu_irq), .irq(irq));
  eir_far u_far (.clock(clock), .rst(rst), .clr(clr), .done_cmd(done_cmd), .alt_cmd(alt_cmd),
    .chan_sync(chan_sync), .cpu_irq(cpu_irq), .xfer_done_event(xd),
    .alt_xfer_done_event(xa), .seen_sync(seen_sync), .seen_irq(seen_irq));
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(logic w, logic [31:0] a, logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clock);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= dat;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) fail_count++;
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic fire(logic [42:0] v, logic [63:0] dn, logic [63:0] al);
    @(posedge clock);
    clr <= 1'b1;
    ev <= v[26:0];
    gpio <= v[42:27];
    done_cmd <= dn;
    alt_cmd <= al;
    @(posedge clock);
    clr <= 1'b0;
    ev <= 27'h0;
    gpio <= 16'h0;
    done_cmd <= 64'h0;
    alt_cmd <= 64'h0;
    repeat (5) @(negedge clock);
  endtask
  function automatic int ch_of(int i);
    int t[27] = '{0, 1, 2, 19, 3, 20, 12, 13, 14, 15, 17, 18, 28, 29, 30, 31, 32, 40,
      -1, -1, -1, -1, -1, -1, -1, -1, -1};
    if (i >= 27) return (i < 31) ? i - 19 : (i < 35) ? i - 27 : i + 13;
    return t[i];
  endfunction
  function automatic int irq_of(int i);
    int t[27] = '{13, 14, 15, -1, 10, -1, -1, -1, -1, -1, -1, -1, -1, -1, -1, -1, -1, -1,
      8, 9, 11, 12, -1, -1, -1, 0, 1};
    if (i >= 27) return (i >= 31 && i < 35) ? i - 27 : -1;
    return t[i];
  endfunction
  function automatic int src_of(int c);
    int t[32] = '{0, 1, 2, 4, 31, 32, 33, 34, 18, 19, 20, 21, 6, 7, 8, 9, 27, 10, 11, 3, 5,
      -1, -1, 22, -1, -1, -1, -1, -1, -1, 23, 24};
    return t[c];
  endfunction
  task automatic t_regs();
    bus(1'b0, `EIR_ADDR_SEL_HIGH, 32'h0);
    chk("sel high", `EIR_SEL_HIGH_RST, rd);
    bus(1'b0, `EIR_ADDR_SEL_LOW, 32'h0);
    chk("sel low", `EIR_SEL_LOW_RST, rd);
    bus(1'b1, 32'h019c0024, 32'hffffffff);
    bus(1'b0, 32'h019c0024, 32'h0);
    chk("unmapped", 64'h0, rd);
    bus(1'b1, `EIR_ADDR_SEL_LOW, 32'hffffffff);
    bus(1'b0, `EIR_ADDR_SEL_LOW, 32'h0);
    chk("sel fields", `EIR_SEL_WMASK, rd);
    be <= 4'h1;
    bus(1'b1, `EIR_ADDR_SEL_LOW, `EIR_SEL_LOW_RST);
    be <= 4'hf;
    bus(1'b0, `EIR_ADDR_SEL_LOW, 32'h0);
    chk("sel lane", 64'h7fff7fa4, rd);
    bus(1'b1, `EIR_ADDR_SEL_LOW, `EIR_SEL_LOW_RST);
    bus(1'b0, `EIR_ADDR_SEL_LOW, 32'h0);
    chk("sel low restore", `EIR_SEL_LOW_RST, rd);
    $display("t_regs done");
  endtask
  task automatic t_pin();
    @(posedge clock);
    clr <= 1'b1;
    pin <= 4'h5;
    @(posedge clock);
    clr <= 1'b0;
    repeat (6) @(negedge clock);
    chk("pin chan", 64'h50, seen_sync);
    chk("pin irq", 64'h50, {48'h0, seen_irq});
    @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    pin <= 4'h0;
    repeat (6) @(negedge clock);
    chk("pin held", 64'h0, seen_sync);
    $display("t_pin done");
  endtask
  task automatic t_map();
    int k;
    for (int i = 0; i < 43; i++) begin
      fire(43'h1 << i, 64'h0, 64'h0);
      k = ch_of(i);
      chk("chan", (k < 0) ? 64'h0 : 64'h1 << k, seen_sync);
      k = irq_of(i);
      chk("irq", (k < 0) ? 64'h0 : 64'h1 << k, {48'h0, seen_irq});
    end
    $display("t_map done");
  endtask
  task automatic t_select();
    int s;
    logic [31:0] lo, hi;
    for (int c = 0; c < 32; c++) begin
      lo = (`EIR_SEL_LOW_RST & 32'hffffffe0) | 32'(c);
      hi = (`EIR_SEL_HIGH_RST & 32'h83ffffff) | (32'(c) << 26);
      bus(1'b1, `EIR_ADDR_SEL_LOW, lo);
      bus(1'b1, `EIR_ADDR_SEL_HIGH, hi);
      bus(1'b0, `EIR_ADDR_SEL_HIGH, 32'h0);
      chk("sel read", hi, rd);
      s = src_of(c);
      fire((s < 0) ? {43{1'b1}} : 43'h1 << s, 64'h0, 64'h0);
      chk("sel irq", (s < 0) ? 64'h0 : 64'h3, {seen_irq[15], seen_irq[4]});
    end
    $display("t_select done");
  endtask
  task automatic t_reset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, `EIR_ADDR_SEL_LOW, 32'h0);
    chk("sel low again", `EIR_SEL_LOW_RST, rd);
    ev <= 27'h4000000;
    bus(1'b0, `EIR_ADDR_IRQ_STATE, 32'h0);
    chk("irq state", 64'h2, rd);
    ev <= 27'h0;
    $display("t_reset done");
  endtask
  task automatic t_capture();
    bus(1'b1, `EIR_ADDR_MASK, 32'h0);
    bus(1'b1, `EIR_ADDR_ENA_LOW, 32'h0);
    fire(43'h2, 64'h0, 64'h0);
    bus(1'b0, `EIR_ADDR_CAPT_LOW, 32'h0);
    chk("capture", 64'h2, rd);
    chk("req off", 64'h0, chan_request);
    bus(1'b1, `EIR_ADDR_CAPT_LOW, 32'h2);
    bus(1'b1, `EIR_ADDR_ENA_LOW, 32'h2);
    fire(43'h2, 64'h0, 64'h0);
    chk("req on", 64'h2, chan_request);
    chk("irq masked", 64'h0, irq);
    bus(1'b1, `EIR_ADDR_MASK, 32'h1);
    fire(43'h2, 64'h0, 64'h0);
    bus(1'b0, `EIR_ADDR_STATUS, 32'h0);
    chk("status", 64'h3, rd);
    chk("irq on", 64'h1, irq);
    bus(1'b1, `EIR_ADDR_STATUS, 32'h1);
    bus(1'b0, `EIR_ADDR_STATUS, 32'h0);
    chk("status clr", 64'h2, rd);
    chk("irq off", 64'h0, irq);
    $display("t_capture done");
  endtask
  task automatic t_done();
    fire(43'h0, 64'h1 << 60, 64'h1 << 21);
    chk("completion", (64'h1 << 60) | (64'h1 << 21), seen_sync);
    bus(1'b0, `EIR_ADDR_CAPT_HIGH, 32'h0);
    chk("capture high", 64'h10000000, rd);
    bus(1'b1, `EIR_ADDR_CAPT_HIGH, 32'h10000000);
    bus(1'b0, `EIR_ADDR_CAPT_HIGH, 32'h0);
    chk("capture high clr", 64'h0, rd);
    $display("t_done done");
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_map();
    t_pin();
    t_select();
    t_reset();
    t_capture();
    t_done();
    summarize();
  end
endmodule
`default_nettype wire
